/* File: rtl/lpo_pkg.sv */
// lpo_pkg: shared constants and types for the lcd panel output timing block
package lpo_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CLK = 8'h08;
  localparam logic [7:0] REG_HORZ = 8'h0c;
  localparam logic [7:0] REG_VERT = 8'h10;
  localparam logic [7:0] REG_PWMDIV = 8'h14;
  localparam logic [7:0] REG_PWMHI = 8'h18;
  localparam logic [7:0] REG_IRQ_STAT = 8'h1c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h20;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_RUN = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_SWAP = 4;
  localparam int STAT_STOPPED = 0;
  localparam int STAT_RUNNING = 1;
  localparam int CLK_BIAS_LO = 10;
  localparam int HORZ_HSW_LO = 16;
  localparam int VERT_VSW_LO = 16;
  localparam int PWM_EN = 12;
  localparam int PWM_HI_B_LO = 12;
  localparam int IRQ_FRAME = 0;
  localparam int IRQ_STOP = 1;
  localparam int IRQ_BITS = 2;
  // ----------------------------------------
  // panel modes
  // ----------------------------------------
  localparam logic [2:0] MODE_MONO4 = 3'h0;
  localparam logic [2:0] MODE_MONO8 = 3'h1;
  localparam logic [2:0] MODE_CSTN_SINGLE = 3'h2;
  localparam logic [2:0] MODE_CSTN_DUAL = 3'h3;
  localparam logic [2:0] MODE_TFT12 = 3'h4;
  localparam logic [2:0] MODE_TFT18 = 3'h5;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [11:0] RST_PWMDIV = 12'h002;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] mode;
    logic swap;
    logic [9:0] pixel_divisor;
    logic [4:0] bias_period;
    logic [10:0] ppl_m1;
    logic [7:0] hsw_m1;
    logic [9:0] lines_m1;
    logic [5:0] vsw_m1;
  } lpo_cfg_type;
  typedef struct packed {
    logic en;
    logic [11:0] div;
    logic [11:0] hi_a;
    logic [11:0] hi_b;
  } lpo_pwm_type;
endpackage : lpo_pkg

/* File: rtl/lpo_pwm_chan.sv */
// lpo_pwm_chan: one pwm clock output compared against the shared divider count
`timescale 1ns/1ps
`default_nettype none
module lpo_pwm_chan
  import lpo_pkg::*;
#(
  parameter int W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // shared divider
  input wire logic en,
  input wire logic [W-1:0] count,
  input wire logic [W-1:0] high_time,
  // pin
  output logic pwm_r
);
  // high for the first high_time counts of each period
  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= en && (count < high_time);
    end
  end
endmodule : lpo_pwm_chan
`default_nettype wire

/* File: rtl/lpo_top.sv */
// lpo_top: lcd panel output timing with avalon register slave
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - drive all panel signals as outputs only
// - stn pins by bus width, rest low
// - tft 12/18 bit mapping, red/blue swap
// - run bit high starts panel output
// - run bit low, halt, raise stopped flag
// - stn frame rises with first pixel clock
// - stn frame falls one pixel after line
// - tft frame changes when line sync ends
// - pixel clock from divisor plus one
// - stn bias toggles every bias+1 lines
// - two pwm clocks, shared divider, enable
module lpo_top
  import lpo_pkg::*;
#(
  parameter int PWM_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq,
  // pixel source
  input wire logic [17:0] pixel_word,
  output logic pixel_fetch,
  // panel pins
  output logic frame_sync_out,
  output logic line_sync_out,
  output logic pixel_clock_out,
  output logic [15:0] pixel_data_out,
  output logic bias_out,
  output logic line_end_strobe,
  output logic pwm_clock_a,
  output logic pwm_clock_b
);
  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic is_tft(input logic [2:0] m);
    return (m == MODE_TFT12) || (m == MODE_TFT18);
  endfunction : is_tft

  // active pixel clocks per line; stn pushes several pixels per clock
  function automatic logic [12:0] active_clocks(input lpo_cfg_type c);
    logic [12:0] ppl;
    logic [12:0] col;
    ppl = {2'h0, c.ppl_m1} + 13'h0001;
    col = ppl + ppl + ppl;
    unique case (c.mode)
      MODE_MONO4: active_clocks = ppl >> 2;
      MODE_MONO8: active_clocks = ppl >> 3;
      MODE_CSTN_SINGLE: active_clocks = col >> 3;
      MODE_CSTN_DUAL: active_clocks = col >> 4;
      default: active_clocks = ppl;
    endcase
  endfunction : active_clocks

  function automatic logic [15:0] map_pins(input logic [2:0] m, input logic sw,
                                           input logic [17:0] w);
    logic [5:0] r;
    logic [5:0] b;
    r = sw ? w[17:12] : w[5:0];
    b = sw ? w[5:0] : w[17:12];
    unique case (m)
      MODE_MONO4: map_pins = {12'h000, w[3:0]};
      MODE_MONO8, MODE_CSTN_SINGLE: map_pins = {8'h00, w[7:0]};
      MODE_CSTN_DUAL: map_pins = w[15:0];
      MODE_TFT12: begin
        r = sw ? {2'h0, w[11:8]} : {2'h0, w[3:0]};
        b = sw ? {2'h0, w[3:0]} : {2'h0, w[11:8]};
        map_pins = {4'h0, b[3:0], w[7:4], r[3:0]};
      end
      MODE_TFT18: map_pins = {b[5:1], w[11:6], r[5:1]};
      default: map_pins = 16'h0000;
    endcase
  endfunction : map_pins

  // ----------------------------------------
  // registers and bus slave
  // ----------------------------------------
  typedef enum logic {ST_IDLE, ST_RUN} lpo_state_type;
  lpo_state_type state_r;
  lpo_cfg_type cfg_r;
  lpo_pwm_type pwm_cfg_r;
  logic run_req_r;
  logic stopped_r;
  logic [IRQ_BITS-1:0] irq_stat_r;
  logic [IRQ_BITS-1:0] irq_mask_r;
  logic [IRQ_BITS-1:0] irq_set;
  logic wr_take;
  logic rd_take;
  logic [31:0] rd_nxt;

  assign wr_take = avs_write && !avs_waitrequest;
  assign rd_take = avs_read && !avs_waitrequest;

  // one wait cycle, then the access is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_comb begin
    rd_nxt = RST_ZERO;
    unique case (avs_address)
      REG_CTRL: rd_nxt = {27'h0, cfg_r.swap, cfg_r.mode, run_req_r};
      REG_STAT: rd_nxt = {30'h0, state_r == ST_RUN, stopped_r};
      REG_CLK: rd_nxt = {17'h0, cfg_r.bias_period, cfg_r.pixel_divisor};
      REG_HORZ: rd_nxt = {8'h0, cfg_r.hsw_m1, 5'h0, cfg_r.ppl_m1};
      REG_VERT: rd_nxt = {10'h0, cfg_r.vsw_m1, 6'h0, cfg_r.lines_m1};
      REG_PWMDIV: rd_nxt = {19'h0, pwm_cfg_r.en, pwm_cfg_r.div};
      REG_PWMHI: rd_nxt = {8'h0, pwm_cfg_r.hi_b, pwm_cfg_r.hi_a};
      REG_IRQ_STAT: rd_nxt = {30'h0, irq_stat_r};
      REG_IRQ_MASK: rd_nxt = {30'h0, irq_mask_r};
      default: rd_nxt = RST_ZERO;
    endcase
  end

  // data is loaded in the wait cycle so it stands at the taking edge
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= RST_ZERO;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      run_req_r <= 1'b0;
      cfg_r <= '0;
      pwm_cfg_r <= '0;
      pwm_cfg_r.div <= RST_PWMDIV;
      irq_mask_r <= '0;
    end else if (wr_take) begin
      unique case (avs_address)
        REG_CTRL: begin
          run_req_r <= avs_writedata[CTRL_RUN];
          cfg_r.mode <= avs_writedata[CTRL_MODE_LO +: 3];
          cfg_r.swap <= avs_writedata[CTRL_SWAP];
        end
        REG_CLK: begin
          cfg_r.pixel_divisor <= avs_writedata[9:0];
          cfg_r.bias_period <= avs_writedata[CLK_BIAS_LO +: 5];
        end
        REG_HORZ: begin
          cfg_r.ppl_m1 <= avs_writedata[10:0];
          cfg_r.hsw_m1 <= avs_writedata[HORZ_HSW_LO +: 8];
        end
        REG_VERT: begin
          cfg_r.lines_m1 <= avs_writedata[9:0];
          cfg_r.vsw_m1 <= avs_writedata[VERT_VSW_LO +: 6];
        end
        REG_PWMDIV: begin
          pwm_cfg_r.div <= avs_writedata[11:0];
          pwm_cfg_r.en <= avs_writedata[PWM_EN];
        end
        REG_PWMHI: begin
          pwm_cfg_r.hi_a <= avs_writedata[11:0];
          pwm_cfg_r.hi_b <= avs_writedata[PWM_HI_B_LO +: 12];
        end
        REG_IRQ_MASK: irq_mask_r <= avs_writedata[IRQ_BITS-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  // read clears only the bits it returned; later events survive
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_r <= '0;
    end else if (rd_take && avs_address == REG_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~avs_readdata[IRQ_BITS-1:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------
  // pixel clock divider
  // ----------------------------------------
  logic [9:0] pdiv_r;
  logic rise;
  logic fall;
  logic pdiv_end;

  assign pdiv_end = (pdiv_r == cfg_r.pixel_divisor);
  assign rise = (state_r == ST_RUN) && pdiv_end && !pixel_clock_out;
  assign fall = (state_r == ST_RUN) && pdiv_end && pixel_clock_out;

  // half period is divisor+1 generator cycles
  always_ff @(posedge clk) begin
    if (rst || state_r == ST_IDLE) begin
      pdiv_r <= '0;
      pixel_clock_out <= 1'b0;
    end else if (pdiv_end) begin
      pdiv_r <= '0;
      pixel_clock_out <= !pixel_clock_out;
    end else begin
      pdiv_r <= pdiv_r + 10'h001;
    end
  end

  // ----------------------------------------
  // line and frame counters
  // ----------------------------------------
  logic [12:0] pix_r;
  logic [9:0] line_r;
  logic [12:0] active;
  logic [12:0] line_len;
  logic line_wrap;
  logic frame_wrap;

  // active clocks per line from panel type
  assign active = active_clocks(cfg_r);
  assign line_len = active + {5'h00, cfg_r.hsw_m1} + 13'h0001;
  assign line_wrap = rise && (pix_r == line_len - 13'h0001);
  assign frame_wrap = line_wrap && (line_r == cfg_r.lines_m1);

  always_ff @(posedge clk) begin
    if (rst || state_r == ST_IDLE) begin
      pix_r <= '0;
      line_r <= '0;
    end else if (line_wrap) begin
      pix_r <= '0;
      line_r <= frame_wrap ? 10'h000 : line_r + 10'h001;
    end else if (rise) begin
      pix_r <= pix_r + 13'h0001;
    end
  end

  // ----------------------------------------
  // run control
  // ----------------------------------------
  logic first_rise_r;
  logic stop_now;

  // halt on the fall after the last line so no runt pixel clock leaves
  assign stop_now = fall && first_rise_r && !run_req_r;

  // stop only at a frame boundary so the panel never sees a torn frame
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      stopped_r <= 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (run_req_r) begin
            state_r <= ST_RUN;
            stopped_r <= 1'b0;
          end
        end
        ST_RUN: begin
          if (stop_now) begin
            state_r <= ST_IDLE;
            stopped_r <= 1'b1;
          end
        end
      endcase
    end
  end

  assign irq_set[IRQ_FRAME] = frame_wrap;
  assign irq_set[IRQ_STOP] = stop_now;

  // ----------------------------------------
  // panel sync outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst || state_r == ST_IDLE) begin
      first_rise_r <= 1'b1;
    end else if (rise) begin
      first_rise_r <= frame_wrap;
    end
  end

  // every panel pin is an output flop
  always_ff @(posedge clk) begin
    if (rst || state_r == ST_IDLE) begin
      line_sync_out <= 1'b0;
      line_end_strobe <= 1'b0;
    end else if (rise) begin
      line_sync_out <= !line_wrap && (pix_r + 13'h0001 >= active);
      line_end_strobe <= !line_wrap && (pix_r + 13'h0001 == active);
    end
  end

  always_ff @(posedge clk) begin
    if (rst || state_r == ST_IDLE) begin
      frame_sync_out <= 1'b0;
    end else if (!is_tft(cfg_r.mode)) begin
      // rises with first pixel clock of frame
      if (rise && first_rise_r) begin
        frame_sync_out <= 1'b1;
      // falls one pixel clock after line sync falls
      end else if (rise && line_r == 10'h001 && pix_r == 13'h0000) begin
        frame_sync_out <= 1'b0;
      end
    end else if (line_wrap) begin
      // toggles as line sync goes inactive
      if (frame_wrap && run_req_r) begin
        frame_sync_out <= 1'b1;
      end else if (line_r == {4'h0, cfg_r.vsw_m1}) begin
        frame_sync_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // bias and pixel data
  // ----------------------------------------
  logic [4:0] bias_cnt_r;

  // toggle after bias_period+1 lines, stn only
  always_ff @(posedge clk) begin
    if (rst || is_tft(cfg_r.mode)) begin
      bias_cnt_r <= '0;
      bias_out <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      // level held while stopped so no bias period is cut short
      bias_cnt_r <= '0;
    end else if (line_wrap) begin
      if (bias_cnt_r == cfg_r.bias_period) begin
        bias_cnt_r <= '0;
        bias_out <= !bias_out;
      end else begin
        bias_cnt_r <= bias_cnt_r + 5'h01;
      end
    end
  end

  // data changes at the rising edge; the panel model latches it on that same rise
  always_ff @(posedge clk) begin
    if (rst || state_r == ST_IDLE) begin
      pixel_data_out <= '0;
      pixel_fetch <= 1'b0;
    end else begin
      pixel_fetch <= 1'b0;
      if (rise) begin
        if (!line_wrap && (pix_r + 13'h0001 < active || first_rise_r)) begin
          // pin mapping with unused pins low
          pixel_data_out <= map_pins(cfg_r.mode, cfg_r.swap, pixel_word);
          pixel_fetch <= 1'b1;
        end else if (line_wrap) begin
          pixel_data_out <= map_pins(cfg_r.mode, cfg_r.swap, pixel_word);
          pixel_fetch <= 1'b1;
        end else begin
          pixel_data_out <= '0;
        end
      end
    end
  end

  // ----------------------------------------
  // pwm clocks
  // ----------------------------------------
  logic [PWM_W-1:0] pwm_cnt_r;
  logic [PWM_W-1:0] pwm_hi [2];
  logic [1:0] pwm_pin;

  assign pwm_hi[0] = pwm_cfg_r.hi_a;
  assign pwm_hi[1] = pwm_cfg_r.hi_b;

  // one period counter for both clocks
  always_ff @(posedge clk) begin
    if (rst || !pwm_cfg_r.en || pwm_cnt_r >= pwm_cfg_r.div) begin
      pwm_cnt_r <= '0;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 12'h001;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_pwm
    lpo_pwm_chan #(.W(PWM_W)) u_chan (
      .clk(clk),
      .rst(rst),
      .en(pwm_cfg_r.en),
      .count(pwm_cnt_r),
      .high_time(pwm_hi[i]),
      .pwm_r(pwm_pin[i])
    );
  end

  assign pwm_clock_a = pwm_pin[0];
  assign pwm_clock_b = pwm_pin[1];
endmodule : lpo_top
`default_nettype wire

/* File: sim/lpo_monitor.sv */
// lpo_monitor: timing checks on the register bus and panel pins
`timescale 1ns/1ps
`default_nettype none
module lpo_monitor
  import lpo_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // panel pins
  input wire logic frame_sync_out,
  input wire logic line_sync_out,
  input wire logic pixel_clock_out,
  input wire logic [15:0] pixel_data_out,
  input wire logic bias_out,
  input wire logic line_end_strobe
);
  logic [2:0] mode_r;
  logic [9:0] div_r;
  logic [4:0] bias_r;
  logic pck_q_r, lin_q_r, bias_q_r, seen_r, bseen_r;
  logic [11:0] hp_r, lf_r;
  logic [5:0] lc_r;
  logic [15:0] unused_mask;
  logic stn, lrise, take;
  assign stn = mode_r < MODE_TFT12;
  assign lrise = line_sync_out && !lin_q_r;
  assign take = avs_write && !avs_waitrequest;
  assign unused_mask = (mode_r == MODE_MONO4) ? 16'hfff0 :
    (mode_r == MODE_MONO8 || mode_r == MODE_CSTN_SINGLE) ? 16'hff00 :
    (mode_r == MODE_TFT12) ? 16'hf000 : 16'h0000;
  // ----------------------------------------
  // shadow of written setup, edge counters
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r <= 3'h0;
      div_r <= 10'h000;
      bias_r <= 5'h00;
    end else if (take && avs_address == REG_CTRL) begin
      mode_r <= avs_writedata[3:1];
    end else if (take && avs_address == REG_CLK) begin
      div_r <= avs_writedata[9:0];
      bias_r <= avs_writedata[14:10];
    end
  end
  always_ff @(posedge clk) begin
    pck_q_r <= pixel_clock_out;
    lin_q_r <= line_sync_out;
    bias_q_r <= bias_out;
    if (rst) begin
      seen_r <= 1'b0;
      bseen_r <= 1'b0;
      hp_r <= 12'h000;
      lf_r <= 12'h000;
      lc_r <= 6'h00;
    end else begin
      // first toggle after start has no known phase, so it is skipped
      seen_r <= seen_r || (pixel_clock_out != pck_q_r);
      hp_r <= (pixel_clock_out != pck_q_r) ? 12'h001 : hp_r + 12'h001;
      lf_r <= (lin_q_r && !line_sync_out) ? 12'h001 : lf_r + 12'h001;
      bseen_r <= bseen_r || (bias_out != bias_q_r);
      lc_r <= (bias_out != bias_q_r) ? 6'h00 : lc_r + {5'h00, lrise};
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking mcb @(posedge clk); endclocking
  default disable iff (rst);
  bus_wait_a:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered");
  strobe_start_a:
    assert property ($rose(line_sync_out) |-> line_end_strobe)
    else $error("line end strobe missing");
  unused_low_a:
    assert property ((pixel_data_out & unused_mask) == 16'h0000)
    else $error("unused data pin driven");
  stn_frame_rise_a:
    assert property (stn && $rose(frame_sync_out) |-> $rose(pixel_clock_out))
    else $error("frame rise off pixel clock");
  stn_frame_fall_a:
    assert property (stn && $fell(frame_sync_out) |-> lf_r == {1'b0, div_r, 1'b0} + 12'h002)
    else $error("frame fall not one pixel clock after line");
  tft_frame_a:
    assert property (!stn && $changed(frame_sync_out) |-> $fell(line_sync_out))
    else $error("frame change off line end");
  pck_half_a:
    assert property (seen_r && $changed(pixel_clock_out) |-> hp_r == {2'b00, div_r} + 12'h001)
    else $error("pixel clock half period wrong");
  bias_period_a:
    assert property (stn && bseen_r && $changed(bias_out) |->
      lc_r + {5'h00, lrise} == {1'b0, bias_r} + 6'h01)
    else $error("bias period wrong");
endmodule : lpo_monitor
`default_nettype wire

/* File: sim/lpo_panel_model.sv */
// lpo_panel_model: passive panel counting pixel clocks per line
`timescale 1ns/1ps
`default_nettype none
module lpo_panel_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // panel pins
  input wire logic line_sync_out,
  input wire logic pixel_clock_out,
  input wire logic [15:0] pixel_data_out,
  // observations
  output logic [15:0] seen_data,
  output logic [15:0] line_clocks,
  output logic [15:0] lines
);
  logic pck_q_r, lin_q_r, prise;
  logic [15:0] cnt_r;
  assign prise = pixel_clock_out && !pck_q_r;
  always_ff @(posedge clk) begin
    pck_q_r <= pixel_clock_out;
    lin_q_r <= line_sync_out;
  end
  // listen only, count clocks over a whole line period
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 16'h0000;
      line_clocks <= 16'h0000;
      lines <= 16'h0000;
    end else if (line_sync_out && !lin_q_r) begin
      line_clocks <= cnt_r + {15'h0000, prise};
      cnt_r <= 16'h0000;
      lines <= lines + 16'h0001;
    end else begin
      cnt_r <= cnt_r + {15'h0000, prise};
    end
  end
  // data latched on pixel clock rise outside line sync
  always_ff @(posedge clk) begin
    if (rst) begin
      seen_data <= 16'h0000;
    end else if (prise && !line_sync_out) begin
      seen_data <= pixel_data_out;
    end
  end
endmodule : lpo_panel_model
`default_nettype wire

/* File: sim/tb_top.sv */
// tb_top: self-checking bench for the lcd panel output block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import lpo_pkg::*;
;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, irq, pixel_fetch;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [17:0] pixel_word;
  logic frame_sync_out, line_sync_out, pixel_clock_out, bias_out, line_end_strobe;
  logic pwm_clock_a, pwm_clock_b;
  logic [15:0] pixel_data_out, seen_data, line_clocks, lines;
  int n_errors = 0;
  int check_count = 0;
  int seed = 87346;
  lpo_top uut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .irq, .pixel_word, .pixel_fetch, .frame_sync_out,
    .line_sync_out, .pixel_clock_out, .pixel_data_out, .bias_out, .line_end_strobe,
    .pwm_clock_a, .pwm_clock_b);
  lpo_panel_model panel (.clk, .rst, .line_sync_out, .pixel_clock_out, .pixel_data_out,
    .seen_data, .line_clocks, .lines);
  task automatic end_of_test;
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  function automatic int exp_clk(input logic [2:0] m, input int hs);
    case (m)
      MODE_MONO4: return 8 + hs;
      MODE_MONO8: return 4 + hs;
      MODE_CSTN_SINGLE: return 12 + hs;
      MODE_CSTN_DUAL: return 6 + hs;
      default: return 32 + hs;
    endcase
  endfunction : exp_clk
  function automatic logic [15:0] exp_tft(input logic [2:0] m, input logic sw,
    input logic [17:0] w);
    logic [5:0] r, g, b, t;
    if (m < MODE_TFT12) return w[15:0] & ((m == MODE_CSTN_DUAL) ? 16'hffff :
      (m == MODE_MONO4) ? 16'h000f : 16'h00ff);
    r = (m == MODE_TFT12) ? {2'b00, w[3:0]} : w[5:0];
    g = (m == MODE_TFT12) ? {2'b00, w[7:4]} : w[11:6];
    b = (m == MODE_TFT12) ? {2'b00, w[11:8]} : w[17:12];
    t = r;
    r = sw ? b : r;
    b = sw ? t : b;
    return (m == MODE_TFT12) ? {4'h0, b[3:0], g[3:0], r[3:0]} : {b[5:1], g, r[5:1]};
  endfunction : exp_tft
  task automatic pwm_test(input logic en);
    logic [31:0] q;
    logic [11:0] dv, ha, hb;
    int na, nb;
    dv = 12'h003 + 12'($unsigned($random(seed)) % 8);
    ha = 12'($unsigned($random(seed)) % (dv + 2));
    hb = 12'($unsigned($random(seed)) % (dv + 2));
    na = 0;
    nb = 0;
    bus(1'b1, REG_PWMHI, {8'h00, hb, ha}, q);
    bus(1'b1, REG_PWMDIV, {19'h0, en, dv}, q);
    repeat (2 * (dv + 1)) @(posedge clk);
    repeat (4 * (dv + 1)) begin
      @(posedge clk);
      na += int'(pwm_clock_a);
      nb += int'(pwm_clock_b);
    end
    check("pwm a high", na, en ? 4 * ha : 0);
    check("pwm b high", nb, en ? 4 * hb : 0);
  endtask : pwm_test
  task automatic run_mode(input logic [2:0] m);
    logic [31:0] q;
    logic sw, pk;
    logic [9:0] dv;
    logic [4:0] bs;
    logic [7:0] hs;
    int tg;
    int nf;
    logic [15:0] k;
    // divisor kept above 2 so every mono mode is legal
    sw = 1'($random(seed));
    dv = 10'h003 + 10'($unsigned($random(seed)) % 2);
    bs = 5'($unsigned($random(seed)) % 4);
    hs = 8'($unsigned($random(seed)) % 3);
    tg = 0;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    pixel_word <= 18'($random(seed));
    bus(1'b1, REG_CLK, {17'h0, bs, dv}, q);
    bus(1'b1, REG_HORZ, {8'h00, hs, 16'h001f}, q);
    bus(1'b1, REG_VERT, 32'h0000_000b, q);
    bus(1'b1, REG_IRQ_MASK, 32'h0000_0001, q);
    bus(1'b1, REG_CTRL, {27'h0, sw, m, 1'b1}, q);
    while (lines < 16'd20) @(posedge clk);
    check("irq frame", irq, 1);
    check("line clocks", line_clocks, exp_clk(m, int'(hs) + 1));
    check("panel data", seen_data, exp_tft(m, sw, pixel_word));
    k = lines;
    while (lines == k) @(posedge clk);
    k = lines;
    nf = 0;
    while (lines == k) begin
      @(posedge clk);
      nf += int'(pixel_fetch);
    end
    check("fetches per line", nf, exp_clk(m, 0));
    bus(1'b0, REG_STAT, 0, q);
    check("stat running", q, 32'h2);
    bus(1'b0, REG_IRQ_STAT, 0, q);
    check("irq stat frame", q[0], 1);
    bus(1'b1, REG_IRQ_MASK, 32'h0000_0002, q);
    repeat (2) @(posedge clk);
    check("irq masked", irq, 0);
    bus(1'b1, REG_CTRL, {27'h0, sw, m, 1'b0}, q);
    q = 0;
    while (q[0] !== 1'b1) bus(1'b0, REG_STAT, 0, q);
    repeat (2) @(posedge clk);
    check("irq stop", irq, 1);
    pk = pixel_clock_out;
    repeat (40) begin
      @(posedge clk);
      tg += int'(pixel_clock_out !== pk);
    end
    check("halted clock", tg, 0);
    bus(1'b0, REG_IRQ_STAT, 0, q);
    check("irq stat stop", q[1], 1);
    repeat (2) @(posedge clk);
    check("irq cleared", irq, 0);
  endtask : run_mode
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    logic [31:0] q;
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    pixel_word = 18'h00000;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, REG_STAT, 0, q);
    check("stat reset", q, 32'h1);
    bus(1'b0, REG_PWMDIV, 0, q);
    check("pwmdiv reset", q, 32'h2);
    bus(1'b1, 8'h24, 32'hffff_ffff, q);
    bus(1'b0, 8'h24, 0, q);
    check("unmapped", q, 0);
    pwm_test(1'b1);
    pwm_test(1'b1);
    pwm_test(1'b0);
    for (int m = 0; m < 6; m++) run_mode(3'(m));
    end_of_test();
  end
  // watchdog well above the longest mode sweep
  initial begin
    repeat (95000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule : tb_top
bind lpo_top lpo_monitor mon (.clk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_waitrequest, .frame_sync_out, .line_sync_out, .pixel_clock_out,
  .pixel_data_out, .bias_out, .line_end_strobe);
`default_nettype wire
